// *** eag_effective_address_generator.sv ***
// Effective address and immediate generator, one registered stage
`timescale 1ns/1ns
`default_nettype none
module eag_effective_address_generator import eag_pkg::*; (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic reqValid,
	input wire eag_req_t req,
	output logic respValid,
	output eag_resp_t resp
);
	// Decoded view of the request, shared by the register groups
	eag_insn_t insnFields;
	logic [31:0] rn;
	logic [31:0] step;
	logic [7:0] imm8;
	logic [31:0] incRn;
	logic [31:0] decRn;
	logic [31:0] disp4Scaled;
	logic [31:0] disp8Scaled;

	// Instruction fields handed on to the load/store unit
	logic [3:0] opcode_r;
	logic [3:0] opcode_nxt;
	logic [3:0] srcReg_r;
	logic [3:0] srcReg_nxt;
	logic [3:0] dstReg_r;
	logic [3:0] dstReg_nxt;

	// Address and memory access flag
	logic [31:0] effAddr_r;
	logic [31:0] effAddr_nxt;
	logic memAccess_r;
	logic memAccess_nxt;

	// Register write-back
	logic regWrite_r;
	logic regWrite_nxt;
	logic [31:0] regWriteData_r;
	logic [31:0] regWriteData_nxt;
	logic [3:0] regWriteIdx_r;
	logic [3:0] regWriteIdx_nxt;

	// Register operand and extended immediate
	logic [31:0] operand_r;
	logic [31:0] operand_nxt;
	logic [31:0] immValue_r;
	logic [31:0] immValue_nxt;

	// Response strobe
	logic valid_r;
	logic valid_nxt;

	// Operand size step 1, 2 or 4
	function automatic logic [31:0] sizeStep(input eag_size_t sz);
		unique case (sz)
			EAG_SZ_BYTE: sizeStep = EAG_STEP_BYTE;
			EAG_SZ_WORD: sizeStep = EAG_STEP_WORD;
			EAG_SZ_LONG: sizeStep = EAG_STEP_LONG;
			default: sizeStep = EAG_STEP_BYTE;
		endcase
	endfunction

	// Zero-extended displacement scaled by operand size
	function automatic logic [31:0] scaleDisp(input logic [7:0] d,
		input eag_size_t sz);
		logic [31:0] z;
		z = {24'h000000, d};
		unique case (sz)
			EAG_SZ_BYTE: scaleDisp = z;
			EAG_SZ_WORD: scaleDisp = {z[30:0], 1'h0};
			EAG_SZ_LONG: scaleDisp = {z[29:0], 2'h0};
			default: scaleDisp = z;
		endcase
	endfunction

	// 32-bit sum, carry out of bit 31 dropped
	function automatic logic [31:0] addWrap(input logic [31:0] a,
		input logic [31:0] b);
		logic [32:0] s;
		s = {1'h0, a} + {1'h0, b};
		addWrap = s[31:0];
	endfunction

	// 32-bit difference, borrow out of bit 31 dropped
	function automatic logic [31:0] subWrap(input logic [31:0] a,
		input logic [31:0] b);
		logic [32:0] d;
		d = {1'h0, a} - {1'h0, b};
		subWrap = d[31:0];
	endfunction

	// Eight-bit immediate widened as the instruction class asks
	function automatic logic [31:0] extendImm(input logic [7:0] i,
		input eag_imm_t kind);
		logic [31:0] z;
		z = {24'h000000, i};
		unique case (kind)
			EAG_IMM_ZERO: extendImm = z;
			EAG_IMM_SIGN: extendImm = {{24{i[7]}}, i};
			EAG_IMM_TRAP: extendImm = z << EAG_TRAP_SHIFT;
			default: extendImm = z;
		endcase
	endfunction

	// Split the sixteen-bit word and form the size-dependent terms
	assign insnFields = eag_insn_t'(req.insnWord);
	assign rn = req.generalRegisterN;
	assign step = sizeStep(req.size);
	assign imm8 = req.insnWord[EAG_IMM_LSB +: 8];
	assign incRn = addWrap(rn, step);
	assign decRn = subWrap(rn, step);
	assign disp4Scaled = scaleDisp({4'h0, insnFields.low4}, req.size);
	assign disp8Scaled = scaleDisp(imm8, req.size);

	// Next field values; they hold while no request is taken
	always_comb begin
		opcode_nxt = opcode_r;
		srcReg_nxt = srcReg_r;
		dstReg_nxt = dstReg_r;
		if (reqValid) begin
			opcode_nxt = insnFields.opcode;
			srcReg_nxt = insnFields.srcReg;
			dstReg_nxt = insnFields.dstReg;
		end
	end

	// Register the fields
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			opcode_r <= '0;
			srcReg_r <= '0;
			dstReg_r <= '0;
		end else begin
			opcode_r <= opcode_nxt;
			srcReg_r <= srcReg_nxt;
			dstReg_r <= dstReg_nxt;
		end
	end

	// Next address and access flag; every sum wraps at 32 bits
	always_comb begin
		effAddr_nxt = effAddr_r;
		memAccess_nxt = memAccess_r;
		if (reqValid) begin
			effAddr_nxt = rn;
			memAccess_nxt = 1'h1;
			unique case (req.mode)
				EAG_M_REG_DIRECT: begin
					memAccess_nxt = 1'h0;
					effAddr_nxt = 32'h00000000;
				end
				EAG_M_REG_INDIRECT: begin
					effAddr_nxt = rn;
				end
				EAG_M_POST_INC: begin
					effAddr_nxt = rn;
				end
				EAG_M_PRE_DEC: begin
					effAddr_nxt = decRn;
				end
				EAG_M_DISP4: begin
					effAddr_nxt = addWrap(rn, disp4Scaled);
				end
				EAG_M_INDEX: begin
					effAddr_nxt = addWrap(rn,
						req.indexRegisterZero);
				end
				EAG_M_GBR_DISP8: begin
					effAddr_nxt = addWrap(req.globalBaseRegister,
						disp8Scaled);
				end
				EAG_M_PC_REG: begin
					effAddr_nxt = addWrap(req.progCounter, rn);
				end
				default: begin
					memAccess_nxt = 1'h0; // Unknown mode code, no access
				end
			endcase
		end
	end

	// Register the address group
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			effAddr_r <= '0;
			memAccess_r <= 1'h0;
		end else begin
			effAddr_r <= effAddr_nxt;
			memAccess_r <= memAccess_nxt;
		end
	end

	// Next write-back; only the stepping modes update the register
	always_comb begin
		regWrite_nxt = regWrite_r;
		regWriteData_nxt = regWriteData_r;
		regWriteIdx_nxt = regWriteIdx_r;
		if (reqValid) begin
			regWrite_nxt = 1'h0;
			regWriteData_nxt = rn;
			regWriteIdx_nxt = insnFields.dstReg;
			case (req.mode)
				EAG_M_POST_INC: begin
					regWrite_nxt = 1'h1;
					regWriteData_nxt = incRn;
				end
				EAG_M_PRE_DEC: begin
					regWrite_nxt = 1'h1;
					regWriteData_nxt = decRn;
				end
				default: begin
					regWrite_nxt = 1'h0; // Register left unchanged
				end
			endcase
		end
	end

	// Register the write-back group
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			regWrite_r <= 1'h0;
			regWriteData_r <= '0;
			regWriteIdx_r <= '0;
		end else begin
			regWrite_r <= regWrite_nxt;
			regWriteData_r <= regWriteData_nxt;
			regWriteIdx_r <= regWriteIdx_nxt;
		end
	end

	// Next operand and immediate
	always_comb begin
		operand_nxt = operand_r;
		immValue_nxt = immValue_r;
		if (reqValid) begin
			operand_nxt = rn;
			immValue_nxt = extendImm(imm8, req.immKind);
		end
	end

	// Register the operand group
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			operand_r <= '0;
			immValue_r <= '0;
		end else begin
			operand_r <= operand_nxt;
			immValue_r <= immValue_nxt;
		end
	end

	// Answer strobe follows each taken request by one cycle
	always_comb begin
		valid_nxt = reqValid;
	end

	// Register the strobe
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			valid_r <= 1'h0;
		end else begin
			valid_r <= valid_nxt;
		end
	end

	// Gather the registered groups into the response
	assign respValid = valid_r;
	assign resp = '{
		effAddr: effAddr_r,
		memAccess: memAccess_r,
		operand: operand_r,
		regWrite: regWrite_r,
		regWriteData: regWriteData_r,
		regWriteIdx: regWriteIdx_r,
		immValue: immValue_r,
		opcode: opcode_r,
		srcReg: srcReg_r,
		dstReg: dstReg_r
	};
endmodule
`default_nettype wire

// *** eag_effective_address_generator_bench.sv ***
// Self-checking bench for the effective address generator
`timescale 1ns/1ns
`default_nettype none
`define CHK(a,b) begin check_count++; if ((a) !== (b)) begin \
	mismatches++; $display("[FAIL] %0t bad value", $time); end end
module eag_effective_address_generator_bench import eag_pkg::*;;
	logic ref_clk = 0, reset = 1, reqValid = 0, respValid;
	eag_req_t req = '0;
	eag_resp_t resp;
	int mismatches = 0, check_count = 0;
	eag_effective_address_generator eag_effective_address_generator_i (
		.ref_clk(ref_clk), .reset(reset), .reqValid(reqValid), .req(req),
		.respValid(respValid), .resp(resp));
	// Core clock
	initial forever #20 ref_clk = ~ref_clk;
	// One request driven at an edge; answer due one cycle later
	task automatic go(eag_mode_t m, eag_size_t s, eag_imm_t k,
		logic [15:0] w, logic [31:0] rn);
		@(posedge ref_clk);
		req <= '{w, m, s, k, rn, 32'h100, 32'h2000, 32'h30000};
		reqValid <= 1'b1;
		@(posedge ref_clk);
		reqValid <= 1'b0;
		#1 `CHK(respValid, 1'b1)
	endtask
	// Size-free modes and immediates
	task t_modes;
		go(EAG_M_REG_DIRECT, EAG_SZ_LONG, EAG_IMM_ZERO, 16'h12f0, 32'h55);
		`CHK({resp.memAccess, resp.operand}, {1'b0, 32'h55})
		`CHK(resp.immValue, 32'hf0)
		go(EAG_M_REG_INDIRECT, EAG_SZ_LONG, EAG_IMM_SIGN, 16'h12f0, 32'h55);
		`CHK({resp.effAddr, resp.regWrite, resp.memAccess}, {32'h55, 2'b01})
		`CHK(resp.immValue, 32'hfffffff0)
		go(EAG_M_INDEX, EAG_SZ_LONG, EAG_IMM_TRAP, 16'h12f0, 32'hfffffff8);
		`CHK(resp.effAddr, 32'hf8)
		`CHK(resp.immValue, 32'h3c0)
		go(EAG_M_PC_REG, EAG_SZ_LONG, EAG_IMM_ZERO, 16'h12f0, 32'h55);
		`CHK(resp.effAddr, 32'h30055)
		`CHK({resp.opcode, resp.dstReg, resp.srcReg}, 12'h12f)
		`CHK(resp.regWriteIdx, 4'h2)
		$display("modes done");
	endtask
	// Sized modes for byte, word and longword
	task t_sizes;
		for (int i = 0; i < 3; i++) begin
			go(EAG_M_POST_INC, eag_size_t'(i), EAG_IMM_ZERO, 16'h12ff, 32'h1000);
			`CHK(resp.effAddr, 32'h1000)
			`CHK(resp.regWriteData, 32'h1000 + (32'h1 << i))
			go(EAG_M_PRE_DEC, eag_size_t'(i), EAG_IMM_ZERO, 16'h12ff, 32'h1000);
			`CHK(resp.effAddr, 32'h1000 - (32'h1 << i))
			`CHK(resp.regWriteData, 32'h1000 - (32'h1 << i))
			go(EAG_M_DISP4, eag_size_t'(i), EAG_IMM_ZERO, 16'h12ff, 32'h1000);
			`CHK(resp.effAddr, 32'h1000 + (32'hf << i))
			go(EAG_M_GBR_DISP8, eag_size_t'(i), EAG_IMM_ZERO, 16'h12ff, 32'h0);
			`CHK(resp.effAddr, 32'h2000 + (32'hff << i))
		end
		$display("sizes done");
	endtask
	// Verdict and end of run
	task stop_test;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Reset, then the scenarios
	initial begin
		repeat (8) @(posedge ref_clk);
		`CHK(respValid, 1'b0)
		reset <= 1'b0;
		@(posedge ref_clk);
		t_modes;
		t_sizes;
		stop_test;
	end
endmodule
bind eag_effective_address_generator eag_sva eag_sva_i (.ref_clk(ref_clk),
	.reset(reset), .reqValid(reqValid), .req(req), .respValid(respValid),
	.resp(resp));
`default_nettype wire

// *** eag_pkg.sv ***
// Package of constants and types for the effective address generator
// Overview of operation
// - Register direct: operand is register content
// - Indirect: address is register, register unchanged
// - Post-increment: old value addresses, then add 1/2/4
// - Pre-decrement: subtract 1/2/4, write back, address
// - 4-bit displacement zero-extended, scaled, plus register
// - Index: register plus index register zero
// - 8-bit displacement zero-extended, scaled, plus global base
// - Target is program counter plus register
// - Logical immediates are zero-extended
// - Move, add, compare immediates are sign-extended
// - Trap immediate zero-extended, times four
// - Word splits into opcode, registers, immediate, displacement
// - Instruction words are exactly sixteen bits
package eag_pkg;
	localparam int EAG_DATA_W = 32;
	localparam int EAG_INSN_W = 16;
	localparam int EAG_DST_LSB = 8;
	localparam int EAG_SRC_LSB = 4;
	localparam int EAG_IMM_LSB = 0;
	localparam logic [31:0] EAG_STEP_BYTE = 32'h00000001;
	localparam logic [31:0] EAG_STEP_WORD = 32'h00000002;
	localparam logic [31:0] EAG_STEP_LONG = 32'h00000004;
	localparam logic [1:0] EAG_TRAP_SHIFT = 2'h2;

	typedef enum logic [3:0] {
		EAG_M_REG_DIRECT,
		EAG_M_REG_INDIRECT,
		EAG_M_POST_INC,
		EAG_M_PRE_DEC,
		EAG_M_DISP4,
		EAG_M_INDEX,
		EAG_M_GBR_DISP8,
		EAG_M_PC_REG
	} eag_mode_t;

	typedef enum logic [1:0] {
		EAG_SZ_BYTE,
		EAG_SZ_WORD,
		EAG_SZ_LONG
	} eag_size_t;

	typedef enum logic [1:0] {
		EAG_IMM_ZERO,
		EAG_IMM_SIGN,
		EAG_IMM_TRAP
	} eag_imm_t;

	// Fields of one sixteen-bit instruction word
	typedef struct packed {
		logic [3:0] opcode;
		logic [3:0] dstReg;
		logic [3:0] srcReg;
		logic [3:0] low4;
	} eag_insn_t;

	// Request from the decoder
	typedef struct packed {
		logic [15:0] insnWord;
		eag_mode_t mode;
		eag_size_t size;
		eag_imm_t immKind;
		logic [31:0] generalRegisterN;
		logic [31:0] indexRegisterZero;
		logic [31:0] globalBaseRegister;
		logic [31:0] progCounter;
	} eag_req_t;

	// Answer to the load/store unit
	typedef struct packed {
		logic [31:0] effAddr;
		logic memAccess;
		logic [31:0] operand;
		logic regWrite;
		logic [31:0] regWriteData;
		logic [3:0] regWriteIdx;
		logic [31:0] immValue;
		logic [3:0] opcode;
		logic [3:0] srcReg;
		logic [3:0] dstReg;
	} eag_resp_t;
endpackage

// *** eag_sva.sv ***
// Checker for the effective address generator
`timescale 1ns/1ns
`default_nettype none
module eag_sva import eag_pkg::*; (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic reqValid,
	input wire eag_req_t req,
	input wire logic respValid,
	input wire eag_resp_t resp
);
	// Every property is timed on the core clock
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	// Step for the operand size, from the package constants
	logic [31:0] stepExp;
	always_comb begin
		case (req.size)
			EAG_SZ_WORD: stepExp = EAG_STEP_WORD;
			EAG_SZ_LONG: stepExp = EAG_STEP_LONG;
			default: stepExp = EAG_STEP_BYTE;
		endcase
	end
	chk_resp_fields: assert property (reqValid |=> respValid &&
		resp.opcode == $past(req.insnWord[15:12])) else $error("bad fields");
	chk_direct_nomem: assert property (reqValid && req.mode ==
		EAG_M_REG_DIRECT |=> !resp.memAccess) else $error("bad direct");
	chk_indirect_addr: assert property (reqValid && req.mode ==
		EAG_M_REG_INDIRECT |=> resp.effAddr == $past(req.generalRegisterN)
		&& !resp.regWrite) else $error("bad indirect");
	chk_post_inc: assert property (reqValid && req.mode ==
		EAG_M_POST_INC |=> resp.regWrite &&
		resp.effAddr == $past(req.generalRegisterN) &&
		resp.regWriteData == $past(req.generalRegisterN) + $past(stepExp))
		else $error("bad inc");
	chk_pre_dec: assert property (reqValid && req.mode ==
		EAG_M_PRE_DEC |=> resp.regWrite &&
		resp.effAddr == $past(req.generalRegisterN) - $past(stepExp) &&
		resp.effAddr == resp.regWriteData) else $error("bad dec");
	chk_index_sum: assert property (reqValid && req.mode ==
		EAG_M_INDEX |=> resp.effAddr == $past(req.generalRegisterN) +
		$past(req.indexRegisterZero)) else $error("bad index");
	chk_pc_sum: assert property (reqValid && req.mode ==
		EAG_M_PC_REG |=> resp.effAddr == $past(req.generalRegisterN) +
		$past(req.progCounter)) else $error("bad pc sum");
	chk_trap_scale: assert property (reqValid && req.immKind ==
		EAG_IMM_TRAP |=> resp.immValue ==
		{22'h0, $past(req.insnWord[7:0]), 2'h0}) else $error("bad trap");
endmodule
`default_nettype wire
